// File: common/cdoe_if.sv
// Serial link between controller and clock divider, with open-drain data resolution
interface cdoe_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda_line;

  // Pull-up wins unless an enabled driver pulls low
  assign sda_line = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport device (
    input scl,
    input sda_line,
    output dev_sda_o,
    output dev_sda_oe
  );

  modport host (
    output scl,
    output host_sda_o,
    output host_sda_oe,
    input sda_line
  );
endinterface : cdoe_if

// File: common/cdoe_map.svh
// Offsets, field positions, reset values and timing counts for the clock divider block
`ifndef CDOE_MAP_SVH
`define CDOE_MAP_SVH

// Output-disable mask: reset value, all pairs enabled
`define CDOE_MASK_RESET 8'h00
`define CDOE_NUM_OUT 8

// Serial frame: 7-bit target address, direction bit, ninth clock for acknowledge
`define CDOE_ADDR_W 7
`define CDOE_ACK_BIT 4'h8
`define CDOE_DIR_READ 1'b1
// Fixed upper address bits: arbitrary value, set per product
`define CDOE_FIXED_ADDR 5'h16

// Controller register offsets (byte addresses on the Wishbone bus)
`define CDOE_REG_CTRL 8'h00
`define CDOE_REG_TXDATA 8'h04
`define CDOE_REG_RXDATA 8'h08
`define CDOE_REG_STATUS 8'h0c

// Controller field positions
`define CDOE_CTRL_GO 0
`define CDOE_CTRL_READ 1
`define CDOE_CTRL_ADDR_LSB 8
`define CDOE_CTRL_ADDR_MSB 14
`define CDOE_STAT_BUSY 0
`define CDOE_STAT_NACK 1
`define CDOE_STAT_DONE 2

// Serial clock timing: quarter of a 100 kHz bit period, at a 250 MHz system clock
`define CDOE_SYS_CLK_MHZ 250
`define CDOE_I2C_QTR_NS 2500
`define CDOE_I2C_QTR_CYC (`CDOE_I2C_QTR_NS * `CDOE_SYS_CLK_MHZ / 1000)

`endif

// File: common/cdoe_pkg.sv
// Types shared by both ends of the clock divider serial link
package cdoe_pkg;

  typedef enum logic [2:0] {
    CDOE_D_IDLE,
    CDOE_D_ADDR,
    CDOE_D_ADDR_ACK,
    CDOE_D_WDATA,
    CDOE_D_WDATA_ACK,
    CDOE_D_RDATA,
    CDOE_D_RDATA_ACK,
    CDOE_D_IGNORE
  } cdoe_dev_state_t;

  typedef enum logic [1:0] {
    CDOE_H_IDLE,
    CDOE_H_START,
    CDOE_H_BIT,
    CDOE_H_STOP
  } cdoe_host_state_t;

endpackage : cdoe_pkg

// File: rtl/cdoe_device.sv
// Clock divider with eight gated output pairs and a serial configuration target
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`include "cdoe_map.svh"
module cdoe_device #(
  parameter int NUM_OUT = `CDOE_NUM_OUT,
  parameter logic [4:0] FIXED_ADDR = `CDOE_FIXED_ADDR
) (
  input wire logic sys_clk,
  input wire logic nrst,
  cdoe_if.device link,
  input wire logic ref_in,
  input wire logic [1:0] divide_select,
  input wire logic addr_strap_hi,
  input wire logic addr_strap_lo,
  output logic [NUM_OUT-1:0] clock_out_p,
  output logic [NUM_OUT-1:0] clock_out_n,
  output logic [NUM_OUT-1:0] clock_out_oe,
  output logic [NUM_OUT-1:0] output_disable_mask
);
  // FIXED_ADDR default is an arbitrary value; set it per product

  if (NUM_OUT != `CDOE_NUM_OUT) begin : g_chk
    $error("cdoe_device: the mask register serves exactly eight pairs");
  end

  // Pin synchronisers
  logic [4:0] pins_s;
  logic [1:0] link_s;
  logic ref_s;
  logic [1:0] sel_s;
  logic strap_hi_s;
  logic strap_lo_s;
  logic scl_s;
  logic sda_s;

  cdoe_sync #(.W(5)) u_pin_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .d({ref_in, divide_select, addr_strap_hi, addr_strap_lo}),
    .q(pins_s)
  );

  cdoe_sync #(.W(2), .RST_VAL(2'h3)) u_link_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .d({link.scl, link.sda_line}),
    .q(link_s)
  );

  assign ref_s = pins_s[4];
  assign sel_s = pins_s[3:2];
  assign strap_hi_s = pins_s[1];
  assign strap_lo_s = pins_s[0];
  assign scl_s = link_s[1];
  assign sda_s = link_s[0];

  // Divider
  // The reference is oversampled, so it must stay below half the system clock.
  logic ref_prev_q;
  logic [1:0] sel_prev_q;
  logic [1:0] div_cnt_q;
  logic [1:0] div_cnt_d;
  logic div_q;
  logic div_d;
  logic ref_rise;
  logic sel_change;
  logic [1:0] half_last;

  assign ref_rise = ref_s & ~ref_prev_q;
  assign sel_change = sel_s != sel_prev_q;
  // Toggle after 1, 2 or 4 reference rises: even duty at /2, /4, /8
  assign half_last = (sel_s == 2'h1) ? 2'h0 : ((sel_s == 2'h2) ? 2'h1 : 2'h3);

  always_comb begin
    div_cnt_d = div_cnt_q;
    div_d = div_q;
    if (sel_s == 2'h0) begin
      div_cnt_d = 2'h0;
      div_d = ref_s;
    end else if (sel_change) begin
      div_cnt_d = 2'h0;
    end else if (ref_rise) begin
      if (div_cnt_q == half_last) begin
        div_cnt_d = 2'h0;
        div_d = ~div_q;
      end else begin
        div_cnt_d = div_cnt_q + 2'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ref_prev_q <= 1'b0;
      sel_prev_q <= 2'h0;
      div_cnt_q <= 2'h0;
      div_q <= 1'b0;
    end else begin
      ref_prev_q <= ref_s;
      sel_prev_q <= sel_s;
      div_cnt_q <= div_cnt_d;
      div_q <= div_d;
    end
  end

  // Serial target
  cdoe_pkg::cdoe_dev_state_t state_q;
  cdoe_pkg::cdoe_dev_state_t state_d;
  logic scl_prev_q;
  logic sda_prev_q;
  logic [3:0] bitcnt_q;
  logic [3:0] bitcnt_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [7:0] tx_q;
  logic [7:0] tx_d;
  logic rw_q;
  logic rw_d;
  logic sda_oe_q;
  logic sda_oe_d;
  logic [7:0] mask_q;
  logic [7:0] mask_d;
  logic [`CDOE_ADDR_W-1:0] target_address;
  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;
  logic shifting_in;
  logic counting;

  assign target_address = {FIXED_ADDR, strap_hi_s, strap_lo_s};
  // Both lines pass equal synchroniser delay, so their order is kept
  assign start_det = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  assign stop_det = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  assign scl_rise = scl_s & ~scl_prev_q;
  assign scl_fall = ~scl_s & scl_prev_q;
  assign shifting_in = (state_q == cdoe_pkg::CDOE_D_ADDR) | (state_q == cdoe_pkg::CDOE_D_WDATA);
  assign counting = shifting_in | (state_q == cdoe_pkg::CDOE_D_RDATA);

  always_comb begin
    state_d = state_q;
    bitcnt_d = bitcnt_q;
    shift_d = shift_q;
    tx_d = tx_q;
    rw_d = rw_q;
    sda_oe_d = sda_oe_q;
    mask_d = mask_q;
    if (start_det) begin
      state_d = cdoe_pkg::CDOE_D_ADDR;
      bitcnt_d = 4'h0;
      sda_oe_d = 1'b0;
    end else if (stop_det) begin
      state_d = cdoe_pkg::CDOE_D_IDLE;
      sda_oe_d = 1'b0;
    end else if (scl_rise) begin
      // Sample while the clock is high
      if (shifting_in) begin
        shift_d = {shift_q[6:0], sda_s};
      end
      if (counting) begin
        bitcnt_d = bitcnt_q + 4'h1;
      end
    end else if (scl_fall) begin
      // Own drive changes only just after a falling clock edge
      case (state_q)
        cdoe_pkg::CDOE_D_ADDR: begin
          if (bitcnt_q == `CDOE_ACK_BIT) begin
            if (shift_q[7:1] == target_address) begin
              sda_oe_d = 1'b1;
              rw_d = shift_q[0];
              state_d = cdoe_pkg::CDOE_D_ADDR_ACK;
            end else begin
              state_d = cdoe_pkg::CDOE_D_IGNORE;
            end
          end
        end
        cdoe_pkg::CDOE_D_ADDR_ACK: begin
          bitcnt_d = 4'h0;
          if (rw_q == `CDOE_DIR_READ) begin
            tx_d = mask_q;
            sda_oe_d = ~mask_q[7];
            state_d = cdoe_pkg::CDOE_D_RDATA;
          end else begin
            sda_oe_d = 1'b0;
            state_d = cdoe_pkg::CDOE_D_WDATA;
          end
        end
        cdoe_pkg::CDOE_D_WDATA: begin
          if (bitcnt_q == `CDOE_ACK_BIT) begin
            mask_d = shift_q;
            sda_oe_d = 1'b1;
            state_d = cdoe_pkg::CDOE_D_WDATA_ACK;
          end
        end
        cdoe_pkg::CDOE_D_WDATA_ACK: begin
          // One data byte per write; further bytes go unacknowledged
          sda_oe_d = 1'b0;
          state_d = cdoe_pkg::CDOE_D_IGNORE;
        end
        cdoe_pkg::CDOE_D_RDATA: begin
          if (bitcnt_q == `CDOE_ACK_BIT) begin
            sda_oe_d = 1'b0;
            state_d = cdoe_pkg::CDOE_D_RDATA_ACK;
          end else begin
            tx_d = {tx_q[6:0], 1'b0};
            sda_oe_d = ~tx_q[6];
          end
        end
        cdoe_pkg::CDOE_D_RDATA_ACK: begin
          state_d = cdoe_pkg::CDOE_D_IGNORE;
        end
        default: begin
          sda_oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= cdoe_pkg::CDOE_D_IDLE;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      bitcnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      rw_q <= 1'b0;
      sda_oe_q <= 1'b0;
      mask_q <= `CDOE_MASK_RESET;
    end else begin
      state_q <= state_d;
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
      bitcnt_q <= bitcnt_d;
      shift_q <= shift_d;
      tx_q <= tx_d;
      rw_q <= rw_d;
      sda_oe_q <= sda_oe_d;
      mask_q <= mask_d;
    end
  end

  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = sda_oe_q;

  // Output stage
  // Enables follow the mask on the next edge, regardless of divider phase
  logic [NUM_OUT-1:0] out_p_q;
  logic [NUM_OUT-1:0] out_n_q;
  logic [NUM_OUT-1:0] out_oe_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      out_p_q <= '0;
      out_n_q <= '0;
      out_oe_q <= '0;
    end else begin
      out_p_q <= {NUM_OUT{div_q}};
      out_n_q <= {NUM_OUT{~div_q}};
      out_oe_q <= ~mask_q;
    end
  end

  assign clock_out_p = out_p_q;
  assign clock_out_n = out_n_q;
  assign clock_out_oe = out_oe_q;
  assign output_disable_mask = mask_q;
endmodule : cdoe_device

// File: rtl/cdoe_host.sv
// Serial bus controller driven by software over classic Wishbone
`include "cdoe_map.svh"
module cdoe_host #(
  parameter int QTR_CYC = `CDOE_I2C_QTR_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  cdoe_if.host link,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  if (QTR_CYC < 2 || QTR_CYC > 65535) begin : g_chk
    $error("cdoe_host: QTR_CYC must lie in 2..65535");
  end

  logic sda_s;

  cdoe_sync #(.W(1), .RST_VAL(1'b1)) u_sda_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .d(link.sda_line),
    .q(sda_s)
  );

  // Bus slave: ack one cycle after the request, write applied at the ack edge
  logic ack_q;
  logic [31:0] rdat_q;
  logic [31:0] rd_word;
  logic wb_req;
  logic wb_wr;
  logic sel_ctrl;
  logic sel_tx;
  logic sel_rx;
  logic sel_stat;
  logic [6:0] addr_q;
  logic read_q;
  logic [7:0] txd_q;
  logic [7:0] rxd_q;
  logic busy_q;
  logic nack_q;
  logic done_q;
  logic go;

  assign wb_req = wb_cyc_i & wb_stb_i;
  assign wb_wr = wb_req & wb_we_i & ack_q;
  assign sel_ctrl = wb_adr_i == `CDOE_REG_CTRL;
  assign sel_tx = wb_adr_i == `CDOE_REG_TXDATA;
  assign sel_rx = wb_adr_i == `CDOE_REG_RXDATA;
  assign sel_stat = wb_adr_i == `CDOE_REG_STATUS;
  assign rd_word = sel_ctrl ? {17'h0_0000, addr_q, 6'h00, read_q, 1'b0} :
                   sel_tx ? {24'h00_0000, txd_q} :
                   sel_rx ? {24'h00_0000, rxd_q} :
                   sel_stat ? {29'h0000_0000, done_q, nack_q, busy_q} : 32'h0000_0000;
  // A start request is ignored while a transfer runs
  assign go = wb_wr & sel_ctrl & wb_sel_i[0] & wb_dat_i[`CDOE_CTRL_GO] & ~busy_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= wb_req & ~ack_q;
      rdat_q <= rd_word;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      addr_q <= 7'h00;
      read_q <= 1'b0;
      txd_q <= 8'h00;
    end else if (wb_wr & ~busy_q) begin
      if (sel_ctrl & wb_sel_i[0]) read_q <= wb_dat_i[`CDOE_CTRL_READ];
      if (sel_ctrl & wb_sel_i[1]) addr_q <= wb_dat_i[`CDOE_CTRL_ADDR_MSB:`CDOE_CTRL_ADDR_LSB];
      if (sel_tx & wb_sel_i[0]) txd_q <= wb_dat_i[7:0];
    end
  end

  // Serial engine, four quarter-bit phases per bit
  cdoe_pkg::cdoe_host_state_t st_q;
  cdoe_pkg::cdoe_host_state_t st_d;
  logic [15:0] tcnt_q;
  logic tick;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic [3:0] bit_d;
  logic byte1_q;
  logic byte1_d;
  logic [7:0] sh_q;
  logic [7:0] sh_d;
  logic scl_q;
  logic scl_d;
  logic oe_q;
  logic oe_d;
  logic nack_d;
  logic [7:0] rxd_d;
  logic txb;
  logic ack_slot;

  assign tick = tcnt_q == 16'(QTR_CYC - 1);
  assign txb = ~(byte1_q & read_q);
  assign ack_slot = bit_q == `CDOE_ACK_BIT;

  always_comb begin
    st_d = st_q;
    bit_d = bit_q;
    byte1_d = byte1_q;
    sh_d = sh_q;
    scl_d = scl_q;
    oe_d = oe_q;
    nack_d = nack_q;
    rxd_d = rxd_q;
    if (tick) begin
      case (st_q)
        cdoe_pkg::CDOE_H_START: begin
          if (ph_q == 2'h1) oe_d = 1'b1;
          if (ph_q == 2'h2) scl_d = 1'b0;
          if (ph_q == 2'h3) begin
            st_d = cdoe_pkg::CDOE_H_BIT;
            bit_d = 4'h0;
            byte1_d = 1'b0;
            sh_d = {addr_q, read_q};
          end
        end
        cdoe_pkg::CDOE_H_BIT: begin
          // Data set only while the clock is low
          if (ph_q == 2'h0) oe_d = txb & ~ack_slot & ~sh_q[7];
          if (ph_q == 2'h1) scl_d = 1'b1;
          if (ph_q == 2'h2) begin
            if (ack_slot & txb) nack_d = sda_s;
            if (~ack_slot & ~txb) sh_d = {sh_q[6:0], sda_s};
          end
          if (ph_q == 2'h3) begin
            scl_d = 1'b0;
            if (~ack_slot & txb) sh_d = {sh_q[6:0], 1'b0};
            if (~ack_slot) begin
              bit_d = bit_q + 4'h1;
            end else if (~byte1_q & ~nack_q) begin
              byte1_d = 1'b1;
              bit_d = 4'h0;
              sh_d = read_q ? 8'h00 : txd_q;
            end else begin
              if (byte1_q & read_q) rxd_d = sh_q;
              st_d = cdoe_pkg::CDOE_H_STOP;
            end
          end
        end
        cdoe_pkg::CDOE_H_STOP: begin
          if (ph_q == 2'h0) oe_d = 1'b1;
          if (ph_q == 2'h1) scl_d = 1'b1;
          if (ph_q == 2'h2) oe_d = 1'b0;
          if (ph_q == 2'h3) st_d = cdoe_pkg::CDOE_H_IDLE;
        end
        default: begin
          scl_d = 1'b1;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= cdoe_pkg::CDOE_H_IDLE;
      tcnt_q <= 16'h0000;
      ph_q <= 2'h0;
      bit_q <= 4'h0;
      byte1_q <= 1'b0;
      sh_q <= 8'h00;
      scl_q <= 1'b1;
      oe_q <= 1'b0;
      nack_q <= 1'b0;
      rxd_q <= 8'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else if (go) begin
      st_q <= cdoe_pkg::CDOE_H_START;
      tcnt_q <= 16'h0000;
      ph_q <= 2'h0;
      nack_q <= 1'b0;
      busy_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tcnt_q <= tick ? 16'h0000 : tcnt_q + 16'h0001;
      ph_q <= tick ? ph_q + 2'h1 : ph_q;
      bit_q <= bit_d;
      byte1_q <= byte1_d;
      sh_q <= sh_d;
      scl_q <= scl_d;
      oe_q <= oe_d;
      nack_q <= nack_d;
      rxd_q <= rxd_d;
      if (tick & (st_q == cdoe_pkg::CDOE_H_STOP) & (ph_q == 2'h3)) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end
    end
  end

  assign link.scl = scl_q;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = oe_q;
endmodule : cdoe_host

// File: rtl/cdoe_sync.sv
// Two-flop synchroniser for inputs arriving from outside the clock domain
module cdoe_sync #(
  parameter int W = 1,
  // Idle-high lines reset to their idle level, so no false edge follows reset
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  if (W < 1) begin : g_chk
    $error("cdoe_sync: W must be at least 1");
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule : cdoe_sync

// File: test/cdoe_link_chk.sv
// Protocol checker for the serial link between the controller and the divider
`include "cdoe_map.svh"
module cdoe_link_chk #(
  parameter logic [4:0] FIXED_ADDR = `CDOE_FIXED_ADDR
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda_line,
  input wire logic addr_strap_hi,
  input wire logic addr_strap_lo
);
  timeunit 1ns;
  timeprecision 1ps;
  logic scl_q, sda_q, ours_q, rd_q, ign_q, idle_q;
  logic [3:0] bit_q;
  logic [1:0] byte_q;
  logic [7:0] shift_q;
  wire [6:0] target = {FIXED_ADDR, addr_strap_hi, addr_strap_lo};
  wire rise = scl & ~scl_q;
  wire start_det = scl & scl_q & sda_q & ~sda_line;
  wire stop_det = scl & scl_q & ~sda_q & sda_line;
  wire ack_slot = rise & (bit_q == 4'h8);
  wire addr_hit = (shift_q[7:1] == target);
  // Frame tracker; restarts on any start so a repeated start is handled alike
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bit_q <= 4'h0;
      byte_q <= 2'h0;
      shift_q <= 8'h00;
      ours_q <= 1'b0;
      rd_q <= 1'b0;
      ign_q <= 1'b0;
      idle_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_line;
      if (start_det) begin
        bit_q <= 4'h0;
        byte_q <= 2'h0;
        ours_q <= 1'b0;
        ign_q <= 1'b0;
        idle_q <= 1'b0;
      end else if (stop_det) begin
        idle_q <= 1'b1;
        ign_q <= 1'b0;
      end else if (ack_slot) begin
        bit_q <= 4'h0;
        if (byte_q != 2'h3) byte_q <= byte_q + 2'h1;
        if (byte_q == 2'h0) begin
          ours_q <= addr_hit;
          rd_q <= shift_q[0];
          ign_q <= ~addr_hit;
        end
      end else if (rise) begin
        bit_q <= bit_q + 4'h1;
        shift_q <= {shift_q[6:0], sda_line};
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  chk_dev_drive_low: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("device drives the data line high");
  chk_host_drive_low: assert property (host_sda_oe |-> !host_sda_o)
    else $error("controller drives the data line high");
  chk_dev_edge_low: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl))
    else $error("device data changed while clock high");
  chk_addr_ack: assert property (ack_slot && byte_q == 2'h0 |-> dev_sda_oe == addr_hit)
    else $error("address acknowledge wrong");
  chk_ack_setup: assert property (ack_slot && byte_q == 2'h0 && addr_hit |-> $past(dev_sda_oe, 2))
    else $error("acknowledge not set up before clock rise");
  chk_ack_hold: assert property (ack_slot && dev_sda_oe |-> dev_sda_oe [*4])
    else $error("acknowledge released during clock high");
  chk_wdata_ack: assert property (ack_slot && byte_q == 2'h1 && ours_q && !rd_q |-> dev_sda_oe)
    else $error("data byte not acknowledged");
  chk_read_release: assert property (ack_slot && byte_q == 2'h1 && rd_q |-> !dev_sda_oe)
    else $error("device holds line in controller acknowledge slot");
  chk_ignore_quiet: assert property (ign_q || idle_q |-> !dev_sda_oe)
    else $error("device drives line while idle or ignoring");
  cover property (ack_slot && byte_q == 2'h1 && ours_q && !rd_q);
  cover property (ack_slot && byte_q == 2'h1 && ours_q && rd_q);
  cover property (ign_q && stop_det);
endmodule : cdoe_link_chk

// File: test/tb_top.sv
// Self-checking bench: controller and divider joined over the serial link
`include "cdoe_map.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, nrst, ref_in, strap_hi, strap_lo, cyc, stb, we, ack_o;
  logic [1:0] div_sel;
  logic [3:0] sel, sel_req;
  logic [2:0] ref_cnt;
  logic [7:0] adr, out_p, out_n, out_oe, mask, exp_mask;
  logic [31:0] wdat, rdat_o, r;
  int num_errors, tests_run, lvl_bad, seed;
  cdoe_if link ();
  cdoe_device i_cdoe_device (.sys_clk(sys_clk), .nrst(nrst), .link(link), .ref_in(ref_in),
    .divide_select(div_sel), .addr_strap_hi(strap_hi), .addr_strap_lo(strap_lo),
    .clock_out_p(out_p), .clock_out_n(out_n), .clock_out_oe(out_oe),
    .output_disable_mask(mask));
  // Short quarter period keeps each two-byte serial frame near 320 cycles
  cdoe_host #(.QTR_CYC(4)) i_cdoe_host (.sys_clk(sys_clk), .nrst(nrst), .link(link),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat_o), .wb_ack_o(ack_o));
  cdoe_link_chk i_cdoe_link_chk (.sys_clk(sys_clk), .nrst(nrst), .scl(link.scl),
    .host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe),
    .dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe), .sda_line(link.sda_line),
    .addr_strap_hi(strap_hi), .addr_strap_lo(strap_lo));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // Reference of ten cycles keeps it well below half the system rate
  always @(posedge sys_clk) begin
    ref_cnt <= (ref_cnt == 3'd4) ? 3'd0 : ref_cnt + 3'd1;
    if (ref_cnt == 3'd4) ref_in <= ~ref_in;
  end
  task automatic fail(input string msg);
    $display("CHECK FAILED t=%0t %s", $time, msg);
    num_errors++;
  endtask : fail
  task automatic close_out();
    if (num_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out
  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) fail($sformatf("reg got %h exp %h", got, exp));
  endtask : cmp_reg
  task automatic cmp_out(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) fail($sformatf("outputs got %h exp %h", got, exp));
  endtask : cmp_out
  task automatic cmp_cnt(input int got, input int exp);
    tests_run++;
    if (got != exp) fail($sformatf("count got %0d exp %0d", got, exp));
  endtask : cmp_cnt
  task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= sel_req;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack_o !== 1'b1 && n < 100);
    if (n >= 100) begin
      fail("no bus ack");
      close_out();
    end
    r = rdat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    sel <= 4'h0;
    @(posedge sys_clk);
  endtask : wb_xfer
  function automatic logic [6:0] tgt();
    return {`CDOE_FIXED_ADDR, strap_hi, strap_lo};
  endfunction : tgt
  task automatic dev_op(input logic [6:0] a, input logic rd, input logic [7:0] wd);
    int n;
    logic nack_exp;
    nack_exp = (a != tgt());
    wb_xfer(1'b1, `CDOE_REG_TXDATA, {24'h00_0000, wd});
    wb_xfer(1'b1, `CDOE_REG_CTRL, {17'h0_0000, a, 6'h00, rd, 1'b1});
    n = 0;
    do begin
      wb_xfer(1'b0, `CDOE_REG_STATUS, 32'h0000_0000);
      n++;
    end while (r[0] !== 1'b0 && n < 500);
    if (n >= 500) begin
      fail("serial op hung");
      close_out();
    end
    cmp_reg(r & 32'h0000_0007, {29'h0000_0000, 1'b1, nack_exp, 1'b0});
    if (!nack_exp && !rd) exp_mask = wd;
    if (!nack_exp && rd) begin
      wb_xfer(1'b0, `CDOE_REG_RXDATA, 32'h0000_0000);
      cmp_reg(r & 32'h0000_00ff, {24'h00_0000, exp_mask});
    end
    repeat (4) @(posedge sys_clk);
    cmp_out(mask, exp_mask);
    cmp_out(out_oe, ~exp_mask);
  endtask : dev_op
  task automatic run_lvl(input logic v, output int cnt);
    cnt = 0;
    while (out_p[0] === v && cnt < 1000) begin
      if (out_p !== {8{out_p[0]}} || out_n !== ~out_p) lvl_bad++;
      @(posedge sys_clk);
      cnt++;
    end
    if (cnt >= 1000) begin
      fail("output clock stuck");
      close_out();
    end
  endtask : run_lvl
  task automatic meas(input logic [1:0] s);
    int hi, lo, d;
    div_sel <= s;
    // Select is synchronised and the divider restarts, so let it settle
    repeat (200) @(posedge sys_clk);
    run_lvl(1'b1, d);
    run_lvl(1'b0, d);
    lvl_bad = 0;
    run_lvl(1'b1, hi);
    run_lvl(1'b0, lo);
    cmp_cnt(hi + lo, 10 << s);
    cmp_cnt(hi, 5 << s);
    cmp_cnt(lvl_bad, 0);
  endtask : meas
  initial begin
    nrst = 1'b0;
    {cyc, stb, we, adr, wdat, sel, div_sel, strap_hi, strap_lo, ref_in, ref_cnt} = '0;
    sel_req = 4'hf;
    {num_errors, tests_run, lvl_bad} = '0;
    exp_mask = 8'h00;
    seed = $urandom(32'hd030_42c8);
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    cmp_out(mask, 8'h00);
    cmp_out(out_oe, 8'hff);
    wb_xfer(1'b0, `CDOE_REG_STATUS, 32'h0000_0000);
    cmp_reg(r, 32'h0000_0000);
    wb_xfer(1'b0, 8'h10, 32'h0000_0000);
    cmp_reg(r, 32'h0000_0000);
    for (int n = 0; n < 8; n++) dev_op(tgt(), 1'b0, 8'h01 << n);
    wb_xfer(1'b0, `CDOE_REG_CTRL, 32'h0000_0000);
    cmp_reg(r, {17'h0_0000, tgt(), 6'h00, 2'h0});
    // Lane 0 not selected: the transmit byte must keep its last value
    sel_req = 4'he;
    wb_xfer(1'b1, `CDOE_REG_TXDATA, 32'h0000_0055);
    sel_req = 4'hf;
    wb_xfer(1'b0, `CDOE_REG_TXDATA, 32'h0000_0000);
    cmp_reg(r, 32'h0000_0080);
    dev_op(tgt(), 1'b1, 8'h00);
    for (int k = 0; k < 4; k++) begin
      {strap_hi, strap_lo} <= 2'($urandom);
      @(posedge sys_clk);
      dev_op(tgt(), 1'b0, 8'($urandom));
      dev_op(tgt(), 1'b1, 8'h00);
      dev_op(tgt() ^ (7'h01 << k), 1'b0, 8'($urandom));
      dev_op(tgt() ^ (7'h01 << k), 1'b1, 8'h00);
    end
    for (int s = 0; s < 4; s++) meas(2'(s));
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    cmp_out(mask, 8'h00);
    cmp_out(out_oe, 8'hff);
    close_out();
  end
endmodule : tb_top
